// *** rtl/pfm_pkg.sv ***
// pfm_pkg: constants and carrier types of the pack fet and monitor block
// assumes: one 10 MHz clock, registers reached over the i2c pins only
package pfm_pkg;

    // ------------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PFM_ADDR_MON      = 8'h03;
    localparam logic [7:0] PFM_ADDR_FET      = 8'h04;
    localparam logic [7:0] PFM_MON_RESET     = 8'h00;
    localparam logic [7:0] PFM_FET_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------------
    localparam int         PFM_FLAG_HI_BIT   = 7;
    localparam int         PFM_FLAG_LO_BIT   = 6;
    localparam int         PFM_SEL_MSB       = 3;
    localparam int         PFM_SLEEP_BIT     = 7;
    localparam int         PFM_LDMON_BIT     = 6;
    localparam int         PFM_CHG_FET_BIT   = 1;
    localparam int         PFM_DSG_FET_BIT   = 0;
    localparam logic [7:0] PFM_MON_MASK      = 8'hcf;
    localparam logic [7:0] PFM_FET_MASK      = 8'hc3;

    // ------------------------------------------------------------------
    // monitor select codes
    // ------------------------------------------------------------------
    localparam logic [3:0] PFM_SEL_OFF       = 4'h0;
    localparam logic [3:0] PFM_SEL_MAX       = 4'h9;

    // ------------------------------------------------------------------
    // i2c link
    // ------------------------------------------------------------------
    localparam logic [6:0] PFM_DEV_ADDR_DEF  = 7'h28;
    localparam logic [3:0] PFM_BITS_PER_BYTE = 4'h8;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic charge_oc;
        logic discharge_oc;
        logic short_circuit;
    } pfm_prot_s;

    typedef struct packed {
        logic charge_oc_auto_off_disable;
        logic discharge_oc_auto_off_disable;
        logic short_circuit_auto_off_disable;
    } pfm_dis_s;

endpackage

// *** rtl/pfm_hold_reg.sv ***
// pfm_hold_reg: one retained register word with write and clear mask
// assumes: supply kept by the bottom cell, so only resetn and clr_mask clear it
`timescale 1ns/10ps
`default_nettype none
module pfm_hold_reg #(
    parameter int             W     = 8,
    parameter logic [W-1:0]   RESET = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic [W-1:0] clr_mask,
    output logic      [W-1:0] q
);
    // ------------------------------------------------------------------
    // storage, clear beats write
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= RESET;
        end else begin
            q <= (wr_en ? wr_data : q) & ~clr_mask;
        end
    end
endmodule // pfm_hold_reg
`default_nettype wire

// *** rtl/pfm_ctrl.sv ***
// pfm_ctrl: i2c slave with monitor select and fet_and_sleep_control registers
// assumes: scl/sda, wake and fault inputs are asynchronous pins;
// auto-off disables come from config logic on ref_clk
//
// Behaviour
// R1 - two user flags in bits 7 and 6
// R2 - user flags survive regulator switched off
// R3 - select 0 idle, 1-7 cells, 8/9 temperatures
// R4 - config contents retained while asleep
// R5 - writing fet bit 7 forces sleep
// R6 - sleep turns off fets, balance, regulator
// R7 - sleep clears charge, discharge, balance enables
// R8 - sleep bit self clears on wake
// R9 - sleep leaves monitor select unchanged
// R10 - bit 6 switches load monitor on/off
// R11 - bit 1 drives the charge fet
// R12 - charge overcurrent clears charge enable unless disabled
// R13 - bit 0 drives the discharge fet
// R14 - discharge fault clears discharge enable unless disabled
// R15 - discharge overcurrent disable stops auto off
// R16 - charge overcurrent disable stops auto off
// R17 - bad select codes ignored, reserved bits zero
// R18 - software writes only defined codes, zero reserved
`timescale 1ns/10ps
`default_nettype none
module pfm_ctrl #(
    parameter logic [6:0] DEV_ADDR = pfm_pkg::PFM_DEV_ADDR_DEF
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe_n,
    input  wire pfm_pkg::pfm_prot_s prot_in,
    input  wire pfm_pkg::pfm_dis_s  dis_in,
    input  wire logic             wake_in,
    output logic                  user_flag_high,
    output logic                  user_flag_low,
    output logic [3:0]            monitor_select,
    output logic                  monitor_power_down,
    output logic                  load_monitor_enable,
    output logic                  charge_fet_drive,
    output logic                  discharge_fet_drive,
    output logic                  regulator_enable,
    output logic                  cell_balance_clear
);
    import pfm_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
        ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
    } pfm_state_e;

    pfm_state_e  st_r;
    logic [1:0]  scl_m_r;
    logic [1:0]  sda_m_r;
    logic        scl_q_r;
    logic        sda_q_r;
    logic [2:0]  prot_m_r;
    pfm_prot_s   prot_r;
    logic        wake_m_r;
    logic        wake_r;
    logic        scl_s;
    logic        sda_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        i2c_start;
    logic        i2c_stop;
    logic [7:0]  sh_r;
    logic [3:0]  cnt_r;
    logic [7:0]  ptr_r;
    logic [7:0]  tx_r;
    logic        rw_r;
    logic        nack_r;
    logic        drive_r;
    logic        wr_r;
    logic [7:0]  wdat_r;
    logic [7:0]  mon_q;
    logic [7:0]  fet_q;
    logic        mon_wr;
    logic        fet_wr;
    logic [7:0]  mon_wdata;
    logic [7:0]  fet_clr;
    logic        sleep_enter;
    logic [3:0]  sel_nxt;
    logic [7:0]  ptr_nxt;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            scl_m_r  <= 2'h3;
            sda_m_r  <= 2'h3;
            scl_q_r  <= 1'b1;
            sda_q_r  <= 1'b1;
            prot_m_r <= 3'h0;
            prot_r   <= '0;
            wake_m_r <= 1'b0;
            wake_r   <= 1'b0;
        end else begin
            scl_m_r  <= {scl_m_r[0], scl_in};
            sda_m_r  <= {sda_m_r[0], sda_in};
            scl_q_r  <= scl_m_r[1];
            sda_q_r  <= sda_m_r[1];
            prot_m_r <= prot_in;
            prot_r   <= prot_m_r;
            wake_m_r <= wake_in;
            wake_r   <= wake_m_r;
        end
    end

    assign scl_s     = scl_m_r[1];
    assign sda_s     = sda_m_r[1];
    assign scl_rise  = scl_s & ~scl_q_r;
    assign scl_fall  = ~scl_s & scl_q_r;
    assign i2c_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign i2c_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign ptr_nxt   = ptr_r + 8'h01;

    // ------------------------------------------------------------------
    // register read mux, reserved bits read zero
    // ------------------------------------------------------------------
    function automatic logic [7:0] reg_read(input logic [7:0] a);
        if (a == PFM_ADDR_MON) begin
            reg_read = mon_q & PFM_MON_MASK; // R17
        end else if (a == PFM_ADDR_FET) begin
            reg_read = fet_q & PFM_FET_MASK; // R17
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    // ------------------------------------------------------------------
    // i2c bit shifter
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sh_r   <= 8'h00;
            nack_r <= 1'b0;
        end else if (scl_rise) begin
            sh_r   <= {sh_r[6:0], sda_s};
            nack_r <= sda_s;
        end
    end

    // ------------------------------------------------------------------
    // i2c byte state machine
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r   <= ST_IDLE;
            cnt_r  <= 4'h0;
            ptr_r  <= 8'h00;
            tx_r   <= 8'h00;
            rw_r   <= 1'b0;
            wr_r   <= 1'b0;
            wdat_r <= 8'h00;
        end else begin
            wr_r <= 1'b0;
            if (i2c_start) begin
                st_r  <= ST_ADDR;
                cnt_r <= 4'h0;
            end else if (i2c_stop) begin
                st_r <= ST_IDLE;
            end else if (scl_rise) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
                case (st_r)
                    ST_ADDR: begin
                        if (cnt_r == PFM_BITS_PER_BYTE) begin
                            if (sh_r[7:1] == DEV_ADDR) begin
                                st_r <= ST_ACK_ADDR;
                                rw_r <= sh_r[0];
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_ADDR: begin
                        cnt_r <= 4'h0;
                        tx_r  <= reg_read(ptr_r);
                        st_r  <= rw_r ? ST_RD : ST_PTR;
                    end
                    ST_PTR: begin
                        if (cnt_r == PFM_BITS_PER_BYTE) begin
                            ptr_r <= sh_r;
                            st_r  <= ST_ACK_PTR;
                        end
                    end
                    ST_ACK_PTR: begin
                        cnt_r <= 4'h0;
                        st_r  <= ST_WR;
                    end
                    ST_WR: begin
                        if (cnt_r == PFM_BITS_PER_BYTE) begin
                            wr_r   <= 1'b1;
                            wdat_r <= sh_r;
                            st_r   <= ST_ACK_WR;
                        end
                    end
                    ST_ACK_WR: begin
                        cnt_r <= 4'h0;
                        ptr_r <= ptr_nxt;
                        st_r  <= ST_WR;
                    end
                    ST_RD: begin
                        if (cnt_r == PFM_BITS_PER_BYTE) begin
                            st_r <= ST_ACK_RD;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                        end
                    end
                    ST_ACK_RD: begin
                        if (nack_r) begin
                            st_r <= ST_IDLE;
                        end else begin
                            cnt_r <= 4'h0;
                            ptr_r <= ptr_nxt;
                            tx_r  <= reg_read(ptr_nxt);
                            st_r  <= ST_RD;
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // sda driver, open drain
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_r <= 1'b0;
        end else begin
            drive_r <= (st_r == ST_ACK_ADDR) || (st_r == ST_ACK_PTR) ||
                       (st_r == ST_ACK_WR) || ((st_r == ST_RD) && !tx_r[7]);
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_r;

    // ------------------------------------------------------------------
    // register write and hardware clear terms
    // ------------------------------------------------------------------
    assign mon_wr      = wr_r && (ptr_r == PFM_ADDR_MON);
    assign fet_wr      = wr_r && (ptr_r == PFM_ADDR_FET);
    assign sleep_enter = fet_wr && wdat_r[PFM_SLEEP_BIT] &&
                         !fet_q[PFM_SLEEP_BIT]; // R5
    // undefined select codes keep the old code
    assign sel_nxt     = (wdat_r[3:0] <= PFM_SEL_MAX) ?
                         wdat_r[3:0] : mon_q[3:0]; // R17
    assign mon_wdata   = {wdat_r[7:4], sel_nxt} & PFM_MON_MASK; // R1 R3

    always_comb begin
        fet_clr = 8'h00;
        fet_clr[PFM_CHG_FET_BIT] = sleep_enter ||
            (prot_r.charge_oc &&
             !dis_in.charge_oc_auto_off_disable); // R7 R12 R16
        fet_clr[PFM_DSG_FET_BIT] = sleep_enter ||
            (prot_r.discharge_oc &&
             !dis_in.discharge_oc_auto_off_disable) ||
            (prot_r.short_circuit &&
             !dis_in.short_circuit_auto_off_disable); // R7 R14 R15
        fet_clr[PFM_SLEEP_BIT] = fet_q[PFM_SLEEP_BIT] && wake_r; // R8
    end

    // retained words, never cleared by the regulator going off
    pfm_hold_reg #(.W(8), .RESET(PFM_MON_RESET)) u_mon_reg ( // R2 R4 R9
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .wr_en    (mon_wr),
        .wr_data  (mon_wdata),
        .clr_mask (8'h00),
        .q        (mon_q)
    );

    pfm_hold_reg #(.W(8), .RESET(PFM_FET_RESET)) u_fet_reg ( // R4 R10
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .wr_en    (fet_wr),
        .wr_data  (wdat_r & PFM_FET_MASK),
        .clr_mask (fet_clr),
        .q        (fet_q)
    );

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            user_flag_high      <= 1'b0;
            user_flag_low       <= 1'b0;
            monitor_select      <= PFM_SEL_OFF;
            monitor_power_down  <= 1'b1;
            load_monitor_enable <= 1'b0;
            charge_fet_drive    <= 1'b0;
            discharge_fet_drive <= 1'b0;
            regulator_enable    <= 1'b1;
            cell_balance_clear  <= 1'b0;
        end else begin
            user_flag_high      <= mon_q[PFM_FLAG_HI_BIT]; // R1
            user_flag_low       <= mon_q[PFM_FLAG_LO_BIT]; // R1
            monitor_select      <= mon_q[PFM_SEL_MSB:0]; // R3
            monitor_power_down  <= (mon_q[3:0] == PFM_SEL_OFF); // R3
            load_monitor_enable <= fet_q[PFM_LDMON_BIT]; // R10
            charge_fet_drive    <= fet_q[PFM_CHG_FET_BIT] &&
                                   !fet_q[PFM_SLEEP_BIT]; // R6 R11
            discharge_fet_drive <= fet_q[PFM_DSG_FET_BIT] &&
                                   !fet_q[PFM_SLEEP_BIT]; // R6 R13
            regulator_enable    <= !fet_q[PFM_SLEEP_BIT]; // R6
            cell_balance_clear  <= sleep_enter; // R6 R7
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_flags_write;
        @(posedge ref_clk) disable iff (!resetn)
        mon_wr |=> (mon_q[7:6] == $past(wdat_r[7:6])) ##1
                   (user_flag_high == mon_q[7]);
    endproperty
    a_flags_write: assert property (p_flags_write) // R1
        else $error("user flags not taken from write");

    property p_flags_retained;
        @(posedge ref_clk) disable iff (!resetn)
        (!regulator_enable && !mon_wr) |=> $stable(mon_q[7:6]);
    endproperty
    a_flags_retained: assert property (p_flags_retained) // R2
        else $error("user flags lost while regulator off");

    property p_sel_power;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 monitor_power_down == (monitor_select == PFM_SEL_OFF);
    endproperty
    a_sel_power: assert property (p_sel_power) // R3
        else $error("monitor power down does not follow select");

    property p_sleep_set;
        @(posedge ref_clk) disable iff (!resetn)
        sleep_enter && !wake_r |=> fet_q[7] ##1 !regulator_enable;
    endproperty
    a_sleep_set: assert property (p_sleep_set) // R5
        else $error("sleep write did not reach sleep");

    property p_sleep_outputs;
        @(posedge ref_clk) disable iff (!resetn)
        fet_q[7] |=> !charge_fet_drive && !discharge_fet_drive &&
                     !regulator_enable;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs) // R6
        else $error("drive left on in sleep");

    property p_sleep_clears;
        @(posedge ref_clk) disable iff (!resetn)
        sleep_enter |=> (fet_q[1:0] == 2'h0) && cell_balance_clear;
    endproperty
    a_sleep_clears: assert property (p_sleep_clears) // R7
        else $error("sleep did not clear enables");

    property p_wake_clears;
        @(posedge ref_clk) disable iff (!resetn)
        fet_q[7] && wake_r |=> !fet_q[7];
    endproperty
    a_wake_clears: assert property (p_wake_clears) // R8
        else $error("sleep bit kept after wake");

    property p_sleep_keeps_sel;
        @(posedge ref_clk) disable iff (!resetn)
        sleep_enter && !mon_wr |=> $stable(mon_q[3:0]);
    endproperty
    a_sleep_keeps_sel: assert property (p_sleep_keeps_sel) // R9
        else $error("sleep changed monitor select");

    property p_ldmon;
        @(posedge ref_clk) disable iff (!resetn)
        fet_wr |=> ##1 load_monitor_enable == $past(wdat_r[6], 2);
    endproperty
    a_ldmon: assert property (p_ldmon) // R10
        else $error("load monitor enable not written");

    property p_chg_auto_off;
        @(posedge ref_clk) disable iff (!resetn)
        prot_r.charge_oc && !dis_in.charge_oc_auto_off_disable
        |=> !fet_q[1] ##1 !charge_fet_drive;
    endproperty
    a_chg_auto_off: assert property (p_chg_auto_off) // R12
        else $error("charge fet kept on in overcurrent");

    property p_dsg_auto_off;
        @(posedge ref_clk) disable iff (!resetn)
        (prot_r.discharge_oc && !dis_in.discharge_oc_auto_off_disable) ||
        (prot_r.short_circuit && !dis_in.short_circuit_auto_off_disable)
        |=> !fet_q[0] ##1 !discharge_fet_drive;
    endproperty
    a_dsg_auto_off: assert property (p_dsg_auto_off) // R14
        else $error("discharge fet kept on in fault");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!resetn)
        (mon_q[5:4] == 2'h0) && (fet_q[5:2] == 4'h0) &&
        (mon_q[3:0] <= PFM_SEL_MAX);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // R17
        else $error("reserved bits or bad code stored");

endmodule // pfm_ctrl
`default_nettype wire

// *** verif/pfm_host_model.sv ***
// pfm_host_model: pack controller acting as i2c bus master
// assumes: sda is the resolved wire with a pull-up, ref_clk is 10 MHz
`timescale 1ns/10ps
`default_nettype none
module pfm_host_model (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------------------------------
    // bit, byte and transfer tasks
    // ------------------------------------------------------------------
    logic nak;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        nak = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic bt(input logic b, output logic r);
        w(2);
        sda_low = ~b;
        w(5);
        scl = 1'b1;
        w(4);
        r = sda;
        w(1);
        scl = 1'b0;
    endtask
    task automatic st;
        w(2);
        sda_low = 1'b0;
        w(3);
        scl = 1'b1;
        w(5);
        sda_low = 1'b1;
        w(5);
        scl = 1'b0;
    endtask
    task automatic sp;
        w(2);
        sda_low = 1'b1;
        w(3);
        scl = 1'b1;
        w(5);
        sda_low = 1'b0;
        w(5);
    endtask
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bt(d[i], r);
        bt(1'b1, r);
        nak = nak | r;
    endtask
    // software writes only what the caller hands over
    task automatic wr(input logic [6:0] dv, input logic [7:0] a, d);
        st;
        tx({dv, 1'b0});
        tx(a);
        tx(d);
        sp;
    endtask
    task automatic rd(input logic [6:0] dv, input logic [7:0] a,
                      output logic [7:0] d);
        logic r;
        st;
        tx({dv, 1'b0});
        tx(a);
        st;
        tx({dv, 1'b1});
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        bt(1'b1, r);
        sp;
    endtask
    // two-byte read: master acks the first byte, naks the second
    task automatic rd2(input logic [6:0] dv, input logic [7:0] a,
                       output logic [15:0] d);
        logic r;
        st;
        tx({dv, 1'b0});
        tx(a);
        st;
        tx({dv, 1'b1});
        for (int i = 15; i >= 0; i--) begin
            bt(1'b1, d[i]);
            if (i == 8) bt(1'b0, r);
        end
        bt(1'b1, r);
        sp;
    endtask
endmodule // pfm_host_model
`default_nettype wire

// *** verif/test_pack_fet_and_monitor_ctrl.sv ***
// test_pack_fet_and_monitor_ctrl: self-checking bench of pfm_ctrl
// assumes: registers reached only through pfm_host_model over i2c
`timescale 1ns/10ps
`default_nettype none
module test_pack_fet_and_monitor_ctrl;
    import pfm_pkg::*;
    // ------------------------------------------------------------------
    // wiring, clock and helpers
    // ------------------------------------------------------------------
    localparam logic [6:0] DA = PFM_DEV_ADDR_DEF;
    logic ref_clk, resetn, wake_in, scl, m_low, sda_out, sda_oe_n;
    logic ufh, ufl, mpd, lme, cfd, dfd, reg_en, cbc_p;
    logic [3:0] msel;
    logic [7:0] q, cbc = 8'h00;
    pfm_prot_s prot;
    pfm_dis_s  dis;
    int mismatches = 0;
    int total_checks = 0;
    wire logic sda = m_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
    pfm_ctrl u_dut (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .prot_in(prot), .dis_in(dis), .wake_in(wake_in),
        .user_flag_high(ufh), .user_flag_low(ufl), .monitor_select(msel),
        .monitor_power_down(mpd), .load_monitor_enable(lme),
        .charge_fet_drive(cfd), .discharge_fet_drive(dfd),
        .regulator_enable(reg_en), .cell_balance_clear(cbc_p));
    pfm_host_model u_mst (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_low(m_low));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (cbc_p === 1'b1) cbc <= cbc + 8'h01;
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic ck(input logic [7:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic [7:0] outs;
        return {4'h0, lme, cfd, dfd, reg_en};
    endfunction
    task automatic t_rst;
        ck(outs(), 8'h01);
        ck({7'h0, mpd}, 8'h01);
        u_mst.rd(DA, PFM_ADDR_MON, q);
        ck(q, PFM_MON_RESET);
        u_mst.rd(DA, PFM_ADDR_FET, q);
        ck(q, PFM_FET_RESET);
        $display("reset test done");
    endtask
    task automatic t_mon;
        logic [7:0] d;
        logic [3:0] s;
        for (int c = 0; c < 16; c++) begin
            d = {c[0], ~c[0], (c > 9) ? 2'b11 : 2'b00, c[3:0]};
            if (c <= 9) s = c[3:0];
            u_mst.wr(DA, PFM_ADDR_MON, d);
            u_mst.rd(DA, PFM_ADDR_MON, q);
            ck(q, {d[7:6], 2'b00, s});
            ck({ufh, ufl, 1'b0, mpd, msel}, {d[7:6], 1'b0, s == 4'h0, s});
        end
        $display("monitor test done");
    endtask
    task automatic t_fet;
        u_mst.wr(DA, PFM_ADDR_FET, 8'h43);
        ck(outs(), 8'h0f);
        u_mst.wr(DA, PFM_ADDR_FET, 8'h3d);
        u_mst.rd(DA, PFM_ADDR_FET, q);
        ck(q, 8'h01);
        ck(outs(), 8'h03);
        $display("fet test done");
    endtask
    task automatic t_fault;
        for (int i = 0; i < 6; i++) begin
            dis = (i > 2) ? (3'b100 >> (i % 3)) : 3'b000;
            u_mst.wr(DA, PFM_ADDR_FET, 8'h03);
            prot = 3'b100 >> (i % 3);
            cyc(6);
            prot = '0;
            cyc(4);
            ck({6'h0, cfd, dfd}, i > 2 ? 8'h03 : (i == 0 ? 8'h01 : 8'h02));
        end
        dis = '0;
        $display("fault test done");
    endtask
    task automatic t_sleep;
        logic [7:0] n;
        u_mst.wr(DA, PFM_ADDR_MON, 8'h85);
        u_mst.wr(DA, PFM_ADDR_FET, 8'h43);
        n = cbc;
        u_mst.wr(DA, PFM_ADDR_FET, 8'hc3);
        ck(outs(), 8'h08);
        ck(cbc - n, 8'h01);
        ck({ufh, ufl, 2'b00, msel}, 8'h85);
        u_mst.rd(DA, PFM_ADDR_FET, q);
        ck(q, 8'hc0);
        wake_in = 1'b1;
        cyc(6);
        wake_in = 1'b0;
        u_mst.rd(DA, PFM_ADDR_FET, q);
        ck(q, 8'h40);
        ck(outs(), 8'h09);
        $display("sleep test done");
    endtask
    task automatic t_addr;
        logic [15:0] b2;
        u_mst.nak = 1'b0;
        u_mst.wr(DA ^ 7'h01, PFM_ADDR_MON, 8'h41);
        ck({7'h0, u_mst.nak}, 8'h01);
        u_mst.nak = 1'b0;
        u_mst.wr(DA, 8'h07, 8'hff);
        u_mst.rd(DA, 8'h07, q);
        ck(q, 8'h00);
        u_mst.rd(DA, PFM_ADDR_MON, q);
        ck(q, 8'h85);
        u_mst.rd2(DA, PFM_ADDR_MON, b2);
        ck(b2[15:8], 8'h85);
        ck(b2[7:0], 8'h40);
        ck({7'h0, u_mst.nak}, 8'h00);
        $display("address test done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        wake_in = 1'b0;
        prot = '0;
        dis = '0;
        cyc(10);
        resetn = 1'b1;
        cyc(4);
        t_rst;
        t_mon;
        t_fet;
        t_fault;
        t_sleep;
        t_addr;
        test_done;
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        test_done;
    end
endmodule // test_pack_fet_and_monitor_ctrl
`default_nettype wire
